/* File: src/rar_pkg.sv */
// Shared constants for the remote alias remap block
package rar_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RAR_OFS_REMOTE_5 = 8'h74;
  localparam logic [7:0] RAR_OFS_REMOTE_6 = 8'h75;
  localparam logic [7:0] RAR_OFS_REMOTE_7 = 8'h76;
  localparam logic [7:0] RAR_OFS_ALIAS_1  = 8'h77;
  localparam logic [7:0] RAR_RESET_VAL    = 8'h00;
  // ----------------------------------------------------------------
  // Field layout and table shape
  // ----------------------------------------------------------------
  localparam int         RAR_ADDR_MSB     = 7;
  localparam int         RAR_ADDR_LSB     = 1;
  localparam int         RAR_ADDR_W       = 7;
  localparam int         RAR_NUM_TGT      = 7;
  localparam int         RAR_IDX_W        = 3;
  localparam logic [6:0] RAR_ADDR_OFF     = 7'h00;
endpackage

/* File: src/rar_match_if.sv */
// Interface between register table and alias matcher
`timescale 1ns/10ps
interface rar_match_if;
  logic [rar_pkg::RAR_ADDR_W-1:0]                          addr;     // Incoming address
  logic [rar_pkg::RAR_NUM_TGT-1:0][rar_pkg::RAR_ADDR_W-1:0] aliases;  // Alias table, index 0 = target 1
  logic [rar_pkg::RAR_NUM_TGT-1:0][rar_pkg::RAR_ADDR_W-1:0] remotes;  // Remote table
  logic                                                    hit;      // Alias matched
  logic                                                    blocked;  // Matched but remote is zero
  logic [rar_pkg::RAR_IDX_W-1:0]                           index;    // Matched target number 1..7
  logic [rar_pkg::RAR_ADDR_W-1:0]                          remote;   // Paired remote address

  modport table_side (output addr, aliases, remotes, input hit, blocked, index, remote);
  modport match_side (input addr, aliases, remotes, output hit, blocked, index, remote);
endinterface

/* File: src/rar_alias_match.sv */
// Combinational alias lookup over one port's mapping table
`timescale 1ns/10ps
module rar_alias_match (
  rar_match_if.match_side m  // Lookup request and answer
);
  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Lowest target number wins if software programs duplicate aliases
  always_comb begin
    m.hit     = 1'b0;
    m.blocked = 1'b0;
    m.index   = '0;
    m.remote  = rar_pkg::RAR_ADDR_OFF;
    for (int i = rar_pkg::RAR_NUM_TGT - 1; i >= 0; i--) begin
      if (m.aliases[i] != rar_pkg::RAR_ADDR_OFF && m.aliases[i] == m.addr) begin
        m.hit     = 1'b1;
        m.index   = 3'(i + 1);
        m.remote  = m.remotes[i];
        m.blocked = (m.remotes[i] == rar_pkg::RAR_ADDR_OFF);
      end
    end
  end
endmodule

/* File: src/rar_remote_alias_remap.sv */
// Remote target and alias mapping table with transaction re-addressing
`timescale 1ns/10ps
module rar_remote_alias_remap (
  input  wire logic       i_clk,                // 50 MHz system clock
  input  wire logic       i_sys_rst,            // Async reset, active high
  input  wire logic       i_second_port_select, // Register access targets second port
  input  wire logic [7:0] i_reg_addr,           // Register offset
  input  wire logic       i_reg_wr,             // Write strobe
  input  wire logic       i_reg_rd,             // Read strobe
  input  wire logic [7:0] i_reg_wdata,          // Write data
  output logic      [7:0] o_reg_rdata,          // Read data, valid cycle after strobe
  output logic            o_reg_rvalid,         // Read data valid pulse
  input  wire logic [27:0] i_remote_1_4_p0,     // Port 0 remote 1..4, 7 bits each, 1 in LSBs
  input  wire logic [27:0] i_remote_1_4_p1,     // Port 1 remote 1..4
  input  wire logic [41:0] i_alias_2_7_p0,      // Port 0 aliases 2..7, 2 in LSBs
  input  wire logic [41:0] i_alias_2_7_p1,      // Port 1 aliases 2..7
  input  wire logic       i_txn_valid,          // Local transaction address pulse
  input  wire logic [6:0] i_txn_addr,           // Local 7-bit target address
  input  wire logic       i_txn_rnw,            // Read not write
  input  wire logic       i_txn_port,           // Link port the transaction uses
  output logic            o_fwd_valid,          // Back-channel forward pulse
  output logic      [6:0] o_fwd_addr,           // Remapped remote address
  output logic            o_fwd_rnw,            // Forwarded direction
  output logic            o_fwd_port,           // Forwarded link port
  output logic      [2:0] o_fwd_index,          // Matched target number
  output logic            o_blocked,            // Alias hit on disabled target pulse
  output logic            o_no_match            // Address not mapped pulse
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][2:0][6:0] remote;  // Remote 5..7 per port
    logic [1:0][6:0]      alias1;  // Alias 1 per port
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 fwd_valid;
    logic [6:0]           fwd_addr;
    logic                 fwd_rnw;
    logic                 fwd_port;
    logic [2:0]           fwd_index;
    logic                 blocked;
    logic                 no_match;
  } rar_state_t;

  rar_state_t  state_reg;   // Registered state
  rar_state_t  state_next;  // Value taken at the next edge
  rar_match_if mif ();      // Lookup request and answer
  logic [2:0]  reg_slot;    // Decoded register slot
  logic [7:0]  rd_word;     // Read value of the selected port
  logic        take_fwd;    // Transaction goes out on the link
  logic        take_block;  // Transaction hits a disabled target
  logic        take_miss;   // Transaction matches no alias

  // Slots of the four mapped offsets; anything else decodes to none
  localparam logic [2:0] SLOT_REMOTE_5 = 3'h0;
  localparam logic [2:0] SLOT_REMOTE_6 = 3'h1;
  localparam logic [2:0] SLOT_REMOTE_7 = 3'h2;
  localparam logic [2:0] SLOT_ALIAS_1  = 3'h3;
  localparam logic [2:0] SLOT_NONE     = 3'h4;

  // Stored address field sits in 7:1 with bit 0 always zero
  function automatic logic [7:0] rar_pack(input logic [6:0] a);
    return {a, 1'b0};
  endfunction

  // Written byte to stored field; bit 0 is dropped on the way in
  function automatic logic [6:0] rar_field(input logic [7:0] d);
    return d[rar_pkg::RAR_ADDR_MSB:rar_pkg::RAR_ADDR_LSB];
  endfunction

  // Offset to slot; shared by the write and read paths so they cannot disagree
  function automatic logic [2:0] rar_slot(input logic [7:0] ofs);
    logic [2:0] s;
    unique case (ofs)
      rar_pkg::RAR_OFS_REMOTE_5: s = SLOT_REMOTE_5;
      rar_pkg::RAR_OFS_REMOTE_6: s = SLOT_REMOTE_6;
      rar_pkg::RAR_OFS_REMOTE_7: s = SLOT_REMOTE_7;
      rar_pkg::RAR_OFS_ALIAS_1:  s = SLOT_ALIAS_1;
      default:                   s = SLOT_NONE;
    endcase
    return s;
  endfunction

  // Entry n of a 7-bit-per-entry input table for the lookup port
  function automatic logic [6:0] rar_pick(input logic p, input logic [41:0] t0,
                                          input logic [41:0] t1, input int n);
    logic [41:0] t;
    t = p ? t1 : t0;
    return t[n*7 +: 7];
  endfunction

  // ----------------------------------------------------------------
  // Table assembly for the transaction's port
  // ----------------------------------------------------------------
  // Only the port carrying the transaction is looked up
  always_comb begin
    mif.addr = i_txn_addr;
    // Remotes 1..4 come in as inputs, 5..7 are held here
    for (int i = 0; i < 4; i++) begin
      mif.remotes[i] = rar_pick(i_txn_port, {14'h0000, i_remote_1_4_p0},
                                {14'h0000, i_remote_1_4_p1}, i);
    end
    for (int i = 0; i < 3; i++) begin
      mif.remotes[i+4] = state_reg.remote[i_txn_port][i];
    end
    // Alias 1 is the only alias held here; 2..7 arrive as inputs
    mif.aliases[0] = state_reg.alias1[i_txn_port];
    for (int i = 0; i < 6; i++) begin
      mif.aliases[i+1] = rar_pick(i_txn_port, i_alias_2_7_p0, i_alias_2_7_p1, i);
    end
  end

  rar_alias_match u_match (
    .m (mif.match_side)
  );

  // ----------------------------------------------------------------
  // Register decode and read mux
  // ----------------------------------------------------------------
  // One decode serves both strobes, so a read and write of one cycle agree
  assign reg_slot = rar_slot(i_reg_addr);

  // Read value of the port picked by the select bit, bit 0 forced low
  always_comb begin
    unique case (reg_slot)
      SLOT_REMOTE_5: rd_word = rar_pack(state_reg.remote[i_second_port_select][0]);
      SLOT_REMOTE_6: rd_word = rar_pack(state_reg.remote[i_second_port_select][1]);
      SLOT_REMOTE_7: rd_word = rar_pack(state_reg.remote[i_second_port_select][2]);
      SLOT_ALIAS_1:  rd_word = rar_pack(state_reg.alias1[i_second_port_select]);
      default:       rd_word = rar_pkg::RAR_RESET_VAL;
    endcase
  end

  // ----------------------------------------------------------------
  // Lookup outcome
  // ----------------------------------------------------------------
  // Exactly one of these rises for a transaction; a zero alias never hits
  assign take_fwd   = i_txn_valid && mif.hit && !mif.blocked;
  assign take_block = i_txn_valid && mif.hit && mif.blocked;
  assign take_miss  = i_txn_valid && !mif.hit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic psel;
    psel       = i_second_port_select;
    state_next = state_reg;
    state_next.rvalid    = 1'b0;
    state_next.fwd_valid = 1'b0;
    state_next.blocked   = 1'b0;
    state_next.no_match  = 1'b0;
    // Register writes keep bits 7:1 only
    if (i_reg_wr) begin
      unique case (reg_slot)
        SLOT_REMOTE_5: state_next.remote[psel][0] = rar_field(i_reg_wdata);
        SLOT_REMOTE_6: state_next.remote[psel][1] = rar_field(i_reg_wdata);
        SLOT_REMOTE_7: state_next.remote[psel][2] = rar_field(i_reg_wdata);
        SLOT_ALIAS_1:  state_next.alias1[psel]    = rar_field(i_reg_wdata);
        default: ;
      endcase
    end
    // Reads return the selected port; unmapped offsets read zero
    if (i_reg_rd) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_word;
    end
    // Transaction outcome: forward, block, or leave unmapped
    if (take_fwd) begin
      state_next.fwd_valid = 1'b1;
      state_next.fwd_addr  = mif.remote;
      state_next.fwd_rnw   = i_txn_rnw;
      state_next.fwd_port  = i_txn_port;
      state_next.fwd_index = mif.index;
    end
    if (take_block) begin
      state_next.blocked = 1'b1;
    end
    if (take_miss) begin
      state_next.no_match = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Zero reset leaves targets 1 and 5..7 disabled until software maps them; targets 2..4 follow the input tables
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Register bus answer; every output comes straight from a flop
  assign o_reg_rdata  = state_reg.rdata;
  assign o_reg_rvalid = state_reg.rvalid;

  // Link forward and lookup outcome; address fields hold between forwards
  assign o_fwd_valid  = state_reg.fwd_valid;
  assign o_fwd_addr   = state_reg.fwd_addr;
  assign o_fwd_rnw    = state_reg.fwd_rnw;
  assign o_fwd_port   = state_reg.fwd_port;
  assign o_fwd_index  = state_reg.fwd_index;
  assign o_blocked    = state_reg.blocked;
  assign o_no_match   = state_reg.no_match;
endmodule

/* File: verification/rar_remap_checker.sv */
// Port assertions for the remote alias remap block
`timescale 1ns/10ps
module rar_remap_checker (
  input wire logic       i_clk,        // Clock
  input wire logic       i_sys_rst,    // Reset
  input wire logic       i_reg_rd,     // Read strobe
  input wire logic [7:0] i_reg_addr,   // Offset
  input wire logic       i_txn_valid,  // Txn pulse
  input wire logic [6:0] i_txn_addr,   // Txn address
  input wire logic       i_txn_rnw,    // Txn direction
  input wire logic [7:0] o_reg_rdata,  // Read data
  input wire logic       o_reg_rvalid, // Read valid
  input wire logic       o_fwd_valid,  // Forward
  input wire logic [6:0] o_fwd_addr,   // Remote address
  input wire logic       o_fwd_rnw,    // Direction
  input wire logic       o_blocked,    // Blocked
  input wire logic       o_no_match    // Miss
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [2:0] ans;
  logic       unmap;
  assign ans = {o_fwd_valid, o_blocked, o_no_match};
  assign unmap = i_reg_addr > 8'h77 || i_reg_addr < 8'h74;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Strobe then answer
  sequence s_rd;
    i_reg_rd ##1 o_reg_rvalid;
  endsequence
  a_rd_answer: assert property (i_reg_rd |-> s_rd)
    else $error("read got no answer");
  a_rsvd_zero: assert property (o_reg_rvalid |-> !o_reg_rdata[0])
    else $error("reserved bit read as one");
  a_unmapped_zero: assert property (i_reg_rd && unmap |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_one_answer: assert property (i_txn_valid |=> $onehot(ans))
    else $error("not one lookup answer");
  a_no_spurious: assert property (ans != 3'h0 |-> $past(i_txn_valid))
    else $error("answer without request");
  a_fwd_nonzero: assert property (o_fwd_valid |-> o_fwd_addr != 7'h00)
    else $error("zero remote forwarded");
  a_zero_alias: assert property (i_txn_valid && i_txn_addr == 7'h00 |=> ans[2:1] == 2'h0)
    else $error("address zero matched");
  a_fwd_dir: assert property (o_fwd_valid |-> o_fwd_rnw == $past(i_txn_rnw))
    else $error("direction lost");
endmodule
bind rar_remote_alias_remap rar_remap_checker i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_txn_valid(i_txn_valid),
  .i_txn_addr(i_txn_addr), .i_txn_rnw(i_txn_rnw), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .o_fwd_valid(o_fwd_valid), .o_fwd_addr(o_fwd_addr),
  .o_fwd_rnw(o_fwd_rnw), .o_blocked(o_blocked), .o_no_match(o_no_match));

/* File: verification/rar_link_partner.sv */
// Back-channel sink standing for the remote deserializer
`timescale 1ns/10ps
module rar_link_partner (
  input  wire logic       i_clk,       // System clock
  input  wire logic       i_fwd_valid, // Forward pulse
  input  wire logic [6:0] i_fwd_addr,  // Remote address
  output logic      [7:0] o_cnt = 8'h00, // Forwards taken
  output logic      [6:0] o_last       // Last address taken
);
  // Takes each forward at once; the link has no flow control to stall
  always @(posedge i_clk) begin
    if (i_fwd_valid) begin
      o_cnt <= o_cnt + 8'h01;
      o_last <= i_fwd_addr;
    end
  end
endmodule

/* File: verification/rar_remote_alias_remap_test.sv */
// Self-checking bench for the remote alias remap block
`timescale 1ns/10ps
module rar_remote_alias_remap_test;
  logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, rd = 1'b0, wr = 1'b0, tv = 1'b0;
  logic        rnw = 1'b0, tport = 1'b0, rvalid, fv, frnw, fport, blk, nm;
  logic [7:0]  ra = 8'h00, wd = 8'h00, rdata, pcnt;
  logic [6:0]  ta = 7'h00, fa, plast;
  logic [2:0]  fidx;
  logic [27:0] rem0 = {7'h04, 7'h03, 7'h02, 7'h11}, rem1 = 28'h0000022;
  logic [41:0] al0 = {14'h0000, 7'h45, 21'h000000}, al1 = 42'h00000000000;
  int          error_cnt = 0, tests_run = 0;
  rar_remote_alias_remap i_dut (.i_clk(clk), .i_sys_rst(rst), .i_second_port_select(sel),
    .i_reg_addr(ra), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_remote_1_4_p0(rem0), .i_remote_1_4_p1(rem1),
    .i_alias_2_7_p0(al0), .i_alias_2_7_p1(al1), .i_txn_valid(tv), .i_txn_addr(ta),
    .i_txn_rnw(rnw), .i_txn_port(tport), .o_fwd_valid(fv), .o_fwd_addr(fa), .o_fwd_rnw(frnw),
    .o_fwd_port(fport), .o_fwd_index(fidx), .o_blocked(blk), .o_no_match(nm));
  rar_link_partner i_peer (.i_clk(clk), .i_fwd_valid(fv), .i_fwd_addr(fa), .o_cnt(pcnt),
    .o_last(plast));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; ra <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Answer is checked in the single cycle it stands
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1; ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  // Kind k is {forward, blocked, miss}; direction flips on every call
  task automatic txn(input logic [6:0] a, input logic p, input logic [2:0] k,
                     input logic [6:0] ea, input logic [2:0] ei);
    @(posedge clk);
    tv <= 1'b1; ta <= a; tport <= p; rnw <= ~rnw;
    @(posedge clk);
    tv <= 1'b0;
    #1;
    chk({5'h00, fv, blk, nm}, {5'h00, k});
    if (k[2]) begin
      chk({fport, fa}, {p, ea});
      chk({5'h00, fidx}, {5'h00, ei});
      chk({7'h00, frnw}, {7'h00, rnw});
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (logic [7:0] a = 8'h74; a != 8'h79; a++) rd_reg(a, 8'h00);
    $display("reset values done");
    for (logic [7:0] a = 8'h74; a != 8'h78; a++) wr_reg(a, {a[3:0], 4'hB});
    for (logic [7:0] a = 8'h74; a != 8'h78; a++) rd_reg(a, {a[3:0], 4'hA});
    @(posedge clk);
    sel <= 1'b1;
    rd_reg(8'h77, 8'h00);
    wr_reg(8'h77, 8'h63);
    rd_reg(8'h77, 8'h62);
    @(posedge clk);
    sel <= 1'b0;
    rd_reg(8'h77, 8'h7A);
    $display("register access done");
    txn(7'h3D, 1'b0, 3'h4, 7'h11, 3'h1);
    txn(7'h31, 1'b1, 3'h4, 7'h22, 3'h1);
    txn(7'h3D, 1'b1, 3'h1, 7'h00, 3'h0);
    txn(7'h45, 1'b0, 3'h4, 7'h25, 3'h5);
    txn(7'h00, 1'b0, 3'h1, 7'h00, 3'h0);
    wr_reg(8'h74, 8'h01);
    txn(7'h45, 1'b0, 3'h2, 7'h00, 3'h0);
    chk(pcnt, 8'h03);
    chk({1'b0, plast}, 8'h25);
    $display("lookup done");
    // Mid-run reset must clear port 0's four held registers and the pulse and read-valid outputs
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    chk({fv, blk, nm, rvalid, 4'h0}, 8'h00);
    rst <= 1'b0;
    for (logic [7:0] a = 8'h74; a != 8'h78; a++) rd_reg(a, 8'h00);
    txn(7'h3D, 1'b0, 3'h1, 7'h00, 3'h0);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
